//--- logic/rlc_interlock.sv
`timescale 1ns/1ns
`include "rlc_map.svh"
module rlc_interlock #(
   parameter logic [31:0] P_DEB_CYC   = `RLC_CYC_DEB,
   parameter logic [31:0] P_MIN_CYC   = `RLC_CYC_MIN,
   parameter logic [31:0] P_MAX_CYC   = `RLC_CYC_MAX,
   parameter logic [31:0] P_SHORT_CYC = `RLC_CYC_SHORT
) (
   // Clock and reset
   input  wire logic i_clk_sys,
   input  wire logic i_rst,
   // Field and configuration
   input  wire logic i_field_clear,
   input  wire logic i_lockout_select_input,
   // Shared reset button pin
   input  wire logic i_reset_button_pin,
   output logic      o_reset_button_pin,
   output logic      o_reset_button_pin_oe_n,
   // Safety outputs
   output logic      o_safety_switch_output_a,
   output logic      o_safety_switch_output_b,
   // Indicators
   output logic      o_main_status_indicator,
   output logic      o_red_indicator,
   output logic      o_yellow_indicator,
   output logic      o_restart_lockout
);
   import rlc_pkg::*;

   // ----------------------------------------------------------------------
   // Debounce of the reset input
   // ----------------------------------------------------------------------
   logic btn_db;

   // Contact bounce would split one press into many short ones.
   rlc_debounce #(
      .P_DEB_CYC (P_DEB_CYC)
   ) u_deb (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_raw     (i_reset_button_pin),
      .o_level   (btn_db)
   );

   // ----------------------------------------------------------------------
   // Press timing
   // ----------------------------------------------------------------------
   logic [31:0] press_cnt_r;
   logic [31:0] press_cnt_nxt;
   logic        btn_prev_r;
   logic        btn_prev_nxt;
   logic        release_ev;
   logic        press_valid;
   logic        short_ev;
   logic        lock_en;

   // The interlock counts as enabled only while the select input is high.
   assign lock_en = i_lockout_select_input; // see RULE8

   // Count starts on the debounced level and saturates at the short figure.
   always_comb begin
      btn_prev_nxt  = btn_db;
      press_cnt_nxt = 32'h0;
      if (btn_db) begin // see RULE10
         if (press_cnt_r < P_SHORT_CYC) begin
            press_cnt_nxt = press_cnt_r + 32'h1;
         end else begin
            press_cnt_nxt = press_cnt_r;
         end
      end
   end

   // Release edge, window check and short detection.
   assign release_ev  = btn_prev_r & ~btn_db;
   assign press_valid = release_ev
                      & (press_cnt_r >= P_MIN_CYC)  // see RULE4
                      & (press_cnt_r <  P_MAX_CYC); // see RULE5
   assign short_ev    = btn_db & (press_cnt_r >= P_SHORT_CYC - 32'h1);

   // Timing registers.
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         press_cnt_r <= 32'h0;
         btn_prev_r  <= 1'h0;
      end else begin
         press_cnt_r <= press_cnt_nxt;
         btn_prev_r  <= btn_prev_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Interlock state machine
   // ----------------------------------------------------------------------
   rlc_state_t state_r;
   rlc_state_t state_nxt;

   // Reset stands for supply loss, so the machine starts locked.
   always_comb begin
      case (state_r)
         RLC_ST_LOCKED: begin
            if (short_ev) begin
               state_nxt = RLC_ST_FAIL; // see RULE6
            end else if (i_field_clear && (!lock_en || press_valid)) begin
               state_nxt = RLC_ST_ON; // see RULE4
            end else begin
               state_nxt = RLC_ST_LOCKED; // see RULE1
            end
         end
         RLC_ST_ON: begin
            if (short_ev) begin
               state_nxt = RLC_ST_FAIL; // see RULE6
            end else if (!i_field_clear) begin
               state_nxt = RLC_ST_LOCKED; // see RULE1
            end else begin
               state_nxt = RLC_ST_ON;
            end
         end
         RLC_ST_FAIL: begin
            // Only a new power-up leaves the failure state.
            state_nxt = RLC_ST_FAIL;
         end
         default: begin
            state_nxt = RLC_ST_FAIL;
         end
      endcase
   end

   // State register.
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         state_r <= RLC_ST_LOCKED;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Output and indicator registers
   // ----------------------------------------------------------------------
   rlc_outs_t outs_r;
   rlc_outs_t outs_nxt;
   logic      on_nxt;

   // Outputs follow the next state so they line up with state_r.
   always_comb begin
      on_nxt          = (state_nxt == RLC_ST_ON);
      outs_nxt.ssw_a  = on_nxt;  // see RULE7
      outs_nxt.ssw_b  = on_nxt;  // see RULE7
      outs_nxt.green  = on_nxt;  // see RULE7
      outs_nxt.red    = ~on_nxt; // see RULE2
      outs_nxt.lamp   = ~on_nxt; // see RULE9
      outs_nxt.yellow = i_field_clear & lock_en
                      & (state_nxt == RLC_ST_LOCKED); // see RULE3
   end

   // Output register; outputs are off during reset, while red and the lamp
   // stay lit, because a supply loss leaves the restart locked.
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         outs_r <= '{red:     `RLC_RST_LIT,
                     lamp:    `RLC_RST_LIT,
                     default: `RLC_RST_OUT}; // see RULE2 RULE9
      end else begin
         outs_r <= outs_nxt;
      end
   end

   // Port mapping; the lamp driver stays enabled, the button pulls high.
   assign o_safety_switch_output_a = outs_r.ssw_a;
   assign o_safety_switch_output_b = outs_r.ssw_b;
   assign o_main_status_indicator  = outs_r.green;
   assign o_red_indicator          = outs_r.red;
   assign o_yellow_indicator       = outs_r.yellow;
   assign o_reset_button_pin       = outs_r.lamp;
   assign o_reset_button_pin_oe_n  = `RLC_OE_DRIVE;
   assign o_restart_lockout        = (state_r != RLC_ST_ON);

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   AST_TRIP_LOCKS: assert property ( // see RULE1
      (state_r == RLC_ST_ON && !i_field_clear)
      |=> !o_safety_switch_output_a ##1 !o_safety_switch_output_a)
      else $error("outputs stayed on after field interruption");

   AST_RED_WHEN_OFF: assert property ( // see RULE2
      !o_safety_switch_output_a |-> o_red_indicator && o_restart_lockout)
      else $error("red indicator off while outputs are off");

   AST_YELLOW_READY: assert property ( // see RULE3
      (state_r == RLC_ST_LOCKED && i_field_clear && lock_en && !short_ev
       && !press_valid) |=> o_yellow_indicator)
      else $error("yellow indicator missing while ready to unlock");

   AST_UNLOCK_ON: assert property ( // see RULE4
      (state_r == RLC_ST_LOCKED && i_field_clear && lock_en && press_valid)
      |=> o_safety_switch_output_a && o_safety_switch_output_b)
      else $error("valid press did not switch on");

   AST_LONG_IGNORED: assert property ( // see RULE5
      (state_r == RLC_ST_LOCKED && lock_en && release_ev
       && press_cnt_r >= P_MAX_CYC) |=> !o_safety_switch_output_a)
      else $error("long press unlocked the outputs");

   AST_SHORT_FAIL: assert property ( // see RULE6
      short_ev |=> (state_r == RLC_ST_FAIL) [*3])
      else $error("held reset input did not force failure");

   AST_GREEN_ON: assert property ( // see RULE7
      o_safety_switch_output_a |->
      o_main_status_indicator && o_safety_switch_output_b && !o_red_indicator)
      else $error("status indicator not green with outputs on");

   AST_LAMP_INV: assert property ( // see RULE9
      o_reset_button_pin == !o_safety_switch_output_b
      && !o_reset_button_pin_oe_n)
      else $error("lamp is not the inverse of the outputs");

   AST_COUNT_DEB: assert property ( // see RULE10
      !btn_db |=> press_cnt_r == 32'h0)
      else $error("press counted without debounced level");

   AST_COUNT_STEP: assert property ( // see RULE10
      (btn_db && $past(btn_db) && press_cnt_r < P_SHORT_CYC)
      |=> press_cnt_r == $past(press_cnt_r) + 32'h1)
      else $error("press counter did not advance");

   COV_UNLOCK: cover property (
      state_r == RLC_ST_LOCKED ##1 state_r == RLC_ST_ON);
   COV_TRIP: cover property (
      state_r == RLC_ST_ON ##1 state_r == RLC_ST_LOCKED);
   COV_FAIL: cover property (
      state_r != RLC_ST_FAIL ##1 state_r == RLC_ST_FAIL);
   COV_LONG: cover property (
      release_ev && press_cnt_r >= P_MAX_CYC);

endmodule : rlc_interlock

//--- logic/rlc_map.svh
// Functional notes
// RULE1: After a field interruption or a loss of supply the outputs stay off until a valid unlock.
// RULE2: The red indicator is on for as long as the restart is locked and the outputs are off.
// RULE3: The yellow indicator is on while the field is clear and the interlock is enabled; the code also requires the locked state.
// RULE4: The operator presses and releases reset within 0.15 to 4 s, and the block then switches on.
// RULE5: A press that has lasted 4 s or more is discarded, even after its release.
// RULE6: A reset input held for 30 s is taken as a short to supply and forces the failure state.
// RULE7: With the field clear and no interlock pending the status indicator is green and outputs on.
// RULE8: The interlock is enabled by holding the select input high and disabled by bridging it.
// RULE9: The reset pin also drives the button lamp as the inverse of the switching output state.
// RULE10: Press time is counted on the internal clock, starting only after the input is debounced.
`ifndef RLC_MAP_SVH
`define RLC_MAP_SVH

// ----------------------------------------------------------------------
// Clock and timing figures
// ----------------------------------------------------------------------
`define RLC_CLK_HZ        64'd100000000
`define RLC_T_MIN_MS      64'd150
`define RLC_T_MAX_MS      64'd4000
`define RLC_T_SHORT_MS    64'd30000
`define RLC_T_DEB_MS      64'd10
`define RLC_CYC_PER_MS    (`RLC_CLK_HZ / 64'd1000)
`define RLC_CYC_MIN       32'(`RLC_T_MIN_MS * `RLC_CYC_PER_MS)
`define RLC_CYC_MAX       32'(`RLC_T_MAX_MS * `RLC_CYC_PER_MS)
`define RLC_CYC_SHORT     32'(`RLC_T_SHORT_MS * `RLC_CYC_PER_MS)
`define RLC_CYC_DEB       32'(`RLC_T_DEB_MS * `RLC_CYC_PER_MS)

// ----------------------------------------------------------------------
// Reset values and pin polarity
// ----------------------------------------------------------------------
`define RLC_CNT_W         32
`define RLC_OE_DRIVE      1'h0
`define RLC_RST_OUT       1'h0
`define RLC_RST_LIT       1'h1

`endif

//--- logic/rlc_pkg.sv
package rlc_pkg;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   // Gray order: locked, on, failure.
   typedef enum logic [1:0] {
      RLC_ST_LOCKED = 2'h0,
      RLC_ST_ON     = 2'h1,
      RLC_ST_FAIL   = 2'h3
   } rlc_state_t;

   // Indicator and output group, registered as one unit.
   typedef struct packed {
      logic ssw_a;
      logic ssw_b;
      logic red;
      logic yellow;
      logic green;
      logic lamp;
   } rlc_outs_t;

endpackage : rlc_pkg

//--- logic/rlc_debounce.sv
`timescale 1ns/1ns
`include "rlc_map.svh"
module rlc_debounce #(
   parameter logic [31:0] P_DEB_CYC = `RLC_CYC_DEB
) (
   // Clock and reset
   input  wire logic i_clk_sys,
   input  wire logic i_rst,
   // Level in and out
   input  wire logic i_raw,
   output logic      o_level
);

   logic [31:0] cnt_r;
   logic [31:0] cnt_nxt;
   logic        lvl_r;
   logic        lvl_nxt;

   // A new level is accepted only after it has held for the full time.
   always_comb begin
      cnt_nxt = 32'h0;
      lvl_nxt = lvl_r;
      if (i_raw != lvl_r) begin
         if (cnt_r >= P_DEB_CYC - 32'h1) begin
            lvl_nxt = i_raw;
         end else begin
            cnt_nxt = cnt_r + 32'h1;
         end
      end
   end

   // State register.
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         cnt_r <= 32'h0;
         lvl_r <= 1'h0;
      end else begin
         cnt_r <= cnt_nxt;
         lvl_r <= lvl_nxt;
      end
   end

   assign o_level = lvl_r;

endmodule : rlc_debounce

//--- tb/rlc_operator_model.sv
`timescale 1ns/1ns
module rlc_operator_model (
   // Clock
   input  wire logic i_clk_sys,
   // Button contact
   output logic      o_pressed
);
   // The contact rests open and only moves on falling edges.
   initial o_pressed = 1'h0;

   // Close the contact for a whole number of cycles, then open it.
   task automatic press(input int unsigned cycles);
      @(negedge i_clk_sys);
      o_pressed = 1'h1;
      repeat (cycles) @(negedge i_clk_sys);
      o_pressed = 1'h0;
   endtask : press
endmodule : rlc_operator_model

//--- tb/rlc_interlock_test.sv
`timescale 1ns/1ns
module rlc_interlock_test;
   import rlc_pkg::*;
   // Short counts keep the run brief; the waits and press lengths below are cycle counts set around them, one press drawn at random from 7 to 16 cycles.
   localparam logic [31:0] P_DEB   = 32'h2;
   localparam logic [31:0] P_MIN   = 32'h5;
   localparam logic [31:0] P_MAX   = 32'h14;
   localparam logic [31:0] P_SHORT = 32'h3C;
   localparam int          SETTLE  = 8;
   // Output vectors: a, b, green, red, yellow, lamp, lockout, oe_n.
   localparam logic [7:0]  V_READY = 8'h1E;
   localparam logic [7:0]  V_HELD  = 8'h16;
   localparam logic [7:0]  V_ON    = 8'hE0;

   logic       i_clk_sys;
   logic       i_rst;
   logic       i_field_clear;
   logic       i_sel;
   logic       pin_in;
   wire  [7:0] seen;
   logic [7:0] exp_q[$];
   int         fail_count;
   int         samples_checked;
   int         cyc = 0;
   event       ev_sample;

   // ----------------------------------------------------------------
   // Design, operator and clock
   // ----------------------------------------------------------------
   rlc_interlock #(
      .P_DEB_CYC(P_DEB), .P_MIN_CYC(P_MIN),
      .P_MAX_CYC(P_MAX), .P_SHORT_CYC(P_SHORT)
   ) dut_u (
      .i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .i_field_clear(i_field_clear), .i_lockout_select_input(i_sel),
      .i_reset_button_pin(pin_in), .o_reset_button_pin(seen[2]),
      .o_reset_button_pin_oe_n(seen[0]),
      .o_safety_switch_output_a(seen[7]), .o_safety_switch_output_b(seen[6]),
      .o_main_status_indicator(seen[5]), .o_red_indicator(seen[4]),
      .o_yellow_indicator(seen[3]), .o_restart_lockout(seen[1])
   );

   rlc_operator_model op_u (.i_clk_sys(i_clk_sys), .o_pressed(pin_in));

   initial begin
      i_clk_sys = 1'h0;
      forever #5 i_clk_sys = ~i_clk_sys;
   end

   // Report a mismatch at once and count every comparison.
   task automatic check(input logic [7:0] got, input logic [7:0] want);
      samples_checked++;
      if (got !== want) begin
         fail_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h",
                  $time, got, want);
      end
   endtask : check

   task automatic end_sim;
      $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim

   // Note an expectation and let the watcher compare it.
   task automatic expect_out(input logic [7:0] v);
      exp_q.push_back(v);
      -> ev_sample;
   endtask : expect_out

   task automatic wait_cyc(input int n);
      repeat (n) @(negedge i_clk_sys);
   endtask : wait_cyc

   // The watcher takes the oldest note whenever a sample is due.
   initial begin
      forever begin
         @(ev_sample);
         check(seen, exp_q.pop_front());
      end
   end

   // A hang past this ceiling counts as a mismatch.
   always @(posedge i_clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fail_count++;
         end_sim();
      end
   end

   initial begin
      fail_count = 0;
      samples_checked = 0;
      i_rst = 1'h1;
      i_field_clear = 1'h1;
      i_sel = 1'h1;
      void'($urandom(9802));
      wait_cyc(8);
      i_rst = 1'h0;
      wait_cyc(2);
      expect_out(V_READY);
      op_u.press(3);
      wait_cyc(SETTLE);
      expect_out(V_READY);
      op_u.press(25);
      wait_cyc(SETTLE);
      expect_out(V_READY);
      op_u.press(7 + $urandom % 10);
      wait_cyc(SETTLE);
      expect_out(V_ON);
      i_field_clear = 1'h0;
      wait_cyc(2);
      expect_out(V_HELD);
      i_field_clear = 1'h1;
      wait_cyc(2);
      expect_out(V_READY);
      op_u.press(70);
      wait_cyc(SETTLE);
      expect_out(V_HELD);
      op_u.press(10);
      wait_cyc(SETTLE);
      expect_out(V_HELD);
      // Supply loss, then the interlock bridged off: automatic restart.
      i_rst = 1'h1;
      i_sel = 1'h0;
      wait_cyc(2);
      expect_out(V_HELD);
      i_rst = 1'h0;
      wait_cyc(3);
      expect_out(V_ON);
      i_field_clear = 1'h0;
      wait_cyc(2);
      expect_out(V_HELD);
      i_field_clear = 1'h1;
      wait_cyc(2);
      expect_out(V_ON);
      wait_cyc(1);
      end_sim();
   end
endmodule : rlc_interlock_test
